// ==== core/rtac_pkg.sv ====
package rtac_pkg;

  // Carrier timing: every air time is counted in carrier periods (125 kHz field)
  localparam int unsigned CARRIER_PERIOD_NS = 8000;

  // Uplink bit lengths in carrier periods
  localparam logic [6:0] BIT_LEN_2K = 7'h40;
  localparam logic [6:0] BIT_LEN_4K = 7'h20;
  localparam logic [6:0] BIT_LEN_8K = 7'h10;

  // Downlink classification thresholds, carrier periods from gap start
  localparam logic [5:0] ZERO_MAX_T = 6'h18;  // 24: between the 22 and 28 lengths
  localparam logic [5:0] EOF_LAST_T = 6'h24;  // 36: an interval longer than 37 periods closes the frame

  // Operating state of the transponder
  localparam logic [1:0] OPST_INIT          = 2'h0;
  localparam logic [1:0] OPST_SELECTED      = 2'h1;
  localparam logic [1:0] OPST_SELF_ANNOUNCE = 2'h2;

  // Identifier request variants in reader-first operation
  localparam logic [1:0] REQ_AC_2K = 2'h0;
  localparam logic [1:0] REQ_AC_4K = 2'h1;
  localparam logic [1:0] REQ_MC_4K = 2'h2;
  localparam logic [1:0] REQ_MC_8K = 2'h3;

  // Self-announce settings
  localparam logic       SA_CODE_MANCHESTER = 1'b0;
  localparam logic [1:0] SA_RATE_4K         = 2'h0;
  localparam logic [1:0] SA_RATE_8K         = 2'h1;
  localparam logic [1:0] SA_RATE_2K         = 2'h2;
  localparam logic [1:0] SA_RATE_2K_PIGEON  = 2'h3;

  // Internal code and rate encodings
  localparam logic [1:0] CODE_AC = 2'h0;
  localparam logic [1:0] CODE_MC = 2'h1;
  localparam logic [1:0] CODE_BP = 2'h2;
  localparam logic [1:0] RATE_2K = 2'h0;
  localparam logic [1:0] RATE_4K = 2'h1;
  localparam logic [1:0] RATE_8K = 2'h2;

  // Transmit word: {rate, code, bit}
  localparam int unsigned TXW_WIDTH = 5;
  localparam int unsigned TXW_BIT   = 0;
  localparam int unsigned TXW_CODE  = 1;
  localparam int unsigned TXW_RATE  = 3;

  // Bit length for an internal rate code
  function automatic logic [6:0] rtac_bit_len(input logic [1:0] rate);
    logic [6:0] len;
    len = BIT_LEN_4K;
    if (rate == RATE_2K) len = BIT_LEN_2K;
    if (rate == RATE_8K) len = BIT_LEN_8K;
    return len;
  endfunction

endpackage

// ==== core/rtac_buf2.sv ====
`timescale 1ns/1ps
`default_nettype none

module rtac_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  logic [WIDTH-1:0] slot_q [2];
  logic [WIDTH-1:0] slot_d [2];
  logic [1:0]       count_q;
  logic [1:0]       count_d;
  logic             push;
  logic             pop;

  // Two slots, head always in slot 0; full at two words
  assign in_ready_o  = (count_q != 2'h2);
  assign out_valid_o = (count_q != 2'h0);
  assign out_data_o  = slot_q[0];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Next slot contents: shift on pop, write behind the surviving word
  always_comb begin
    slot_d[0] = slot_q[0];
    slot_d[1] = slot_q[1];
    count_d   = count_q;
    if (pop) begin
      slot_d[0] = slot_q[1];
    end
    if (push) begin
      if (count_q == 2'h0 || (count_q == 2'h1 && pop)) begin
        slot_d[0] = in_data_i;
      end else begin
        slot_d[1] = in_data_i;
      end
    end
    count_d = count_q + {1'b0, push} - {1'b0, pop};
  end

  // Register slots and fill count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
      count_q   <= 2'h0;
    end else begin
      slot_q[0] <= slot_d[0];
      slot_q[1] <= slot_d[1];
      count_q   <= count_d;
    end
  end

endmodule

`default_nettype wire

// ==== core/rtac_air_coding.sv ====
`timescale 1ns/1ps
`default_nettype none

module rtac_air_coding (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       carrier_clk_i,
  input  wire logic       field_i,
  output logic            load_mod_o,
  input  wire logic [1:0] op_state_i,
  input  wire logic [1:0] req_variant_i,
  input  wire logic       self_announce_code_bit_i,
  input  wire logic [1:0] self_announce_rate_field_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_bit_i,
  output logic            tx_ready_o,
  output logic            rx_valid_o,
  output logic            rx_bit_o,
  output logic            rx_eof_o,
  output logic            pigeon_race_o
);

  localparam int unsigned TW = rtac_pkg::TXW_WIDTH;

  logic [1:0]    sel_code;
  logic [1:0]    sel_rate;
  logic [TW-1:0] push_word;

  // Reader-first states never yield a combination outside the allowed set
  always_comb begin
    sel_code = rtac_pkg::CODE_MC;
    sel_rate = rtac_pkg::RATE_4K;
    unique case (op_state_i)
      rtac_pkg::OPST_INIT: begin
        sel_code = rtac_pkg::CODE_AC;
        sel_rate = (req_variant_i == rtac_pkg::REQ_AC_2K) ? rtac_pkg::RATE_2K
                                                          : rtac_pkg::RATE_4K;
      end
      rtac_pkg::OPST_SELECTED: begin
        sel_code = rtac_pkg::CODE_MC;
        sel_rate = (req_variant_i == rtac_pkg::REQ_MC_8K) ? rtac_pkg::RATE_8K
                                                          : rtac_pkg::RATE_4K;
      end
      rtac_pkg::OPST_SELF_ANNOUNCE: begin
        sel_code = (self_announce_code_bit_i == rtac_pkg::SA_CODE_MANCHESTER)
                   ? rtac_pkg::CODE_MC : rtac_pkg::CODE_BP;
        unique case (self_announce_rate_field_i)
          rtac_pkg::SA_RATE_4K:        sel_rate = rtac_pkg::RATE_4K;
          rtac_pkg::SA_RATE_8K:        sel_rate = rtac_pkg::RATE_8K;
          rtac_pkg::SA_RATE_2K, rtac_pkg::SA_RATE_2K_PIGEON: sel_rate = rtac_pkg::RATE_2K;
        endcase
      end
      default: ;  // Reserved state code keeps the legal reader-first defaults above
    endcase
  end

  // Settings are bound to each bit when it enters the buffer
  assign push_word = {sel_rate, sel_code, tx_bit_i};

  logic          tx_ack_q;
  logic          buf_valid;
  logic          buf_ready;
  logic [TW-1:0] buf_data;
  logic          req_q;
  logic          req_d;
  logic [TW-1:0] hs_word_q;
  logic [TW-1:0] hs_word_d;
  logic          ack_s1_q;
  logic          ack_s2_q;
  logic          pigeon_q;
  logic          pigeon_d;

  // A stalled link leaves words in the buffer and drops tx_ready_o
  rtac_buf2 #(.WIDTH (TW)) u_tx_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   (push_word),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_data)
  );

  // A new word may be offered only once the carrier side acked the last one
  assign buf_ready = (ack_s2_q == req_q);

  // Toggle request; word stays stable until the matching ack returns
  always_comb begin
    req_d     = req_q;
    hs_word_d = hs_word_q;
    if (buf_valid && buf_ready) begin
      req_d     = ~req_q;
      hs_word_d = buf_data;
    end
    pigeon_d = (op_state_i == rtac_pkg::OPST_SELF_ANNOUNCE) &&
               (self_announce_rate_field_i == rtac_pkg::SA_RATE_2K_PIGEON);
  end

  // Register handshake state and the ack synchroniser
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q     <= 1'b0;
      hs_word_q <= '0;
      ack_s1_q  <= 1'b0;
      ack_s2_q  <= 1'b0;
      pigeon_q  <= 1'b0;
    end else begin
      req_q     <= req_d;
      hs_word_q <= hs_word_d;
      ack_s1_q  <= tx_ack_q;
      ack_s2_q  <= ack_s1_q;
      pigeon_q  <= pigeon_d;
    end
  end

  assign pigeon_race_o = pigeon_q;

  logic sym_tog_q;
  logic sym_bit_q;
  logic sym_eof_q;
  logic rxt_s1_q;
  logic rxt_s2_q;
  logic rxt_prev_q;
  logic rx_valid_q;
  logic rx_valid_d;
  logic rx_bit_q;
  logic rx_bit_d;
  logic rx_eof_q;
  logic rx_eof_d;

  // Carrier side holds symbol data a whole interval, far longer than the toggle crossing
  always_comb begin
    rx_valid_d = (rxt_s2_q != rxt_prev_q);
    rx_bit_d   = rx_bit_q;
    rx_eof_d   = rx_eof_q;
    if (rx_valid_d) begin
      rx_bit_d = sym_bit_q;
      rx_eof_d = sym_eof_q;
    end
  end

  // Register receive outputs and toggle synchroniser
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxt_s1_q   <= 1'b0;
      rxt_s2_q   <= 1'b0;
      rxt_prev_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_bit_q   <= 1'b0;
      rx_eof_q   <= 1'b0;
    end else begin
      rxt_s1_q   <= sym_tog_q;
      rxt_s2_q   <= rxt_s1_q;
      rxt_prev_q <= rxt_s2_q;
      rx_valid_q <= rx_valid_d;
      rx_bit_q   <= rx_bit_d;
      rx_eof_q   <= rx_eof_d;
    end
  end

  assign rx_valid_o = rx_valid_q;
  assign rx_bit_o   = rx_bit_q;
  assign rx_eof_o   = rx_eof_q;

  logic c_rst_s1_q;
  logic c_rst_n_q;
  logic req_s1_q;
  logic req_s2_q;
  logic fld_s1_q;
  logic fld_s2_q;
  logic fld_prev_q;

  // Reset asserts at once and releases in step with the carrier clock
  always_ff @(posedge carrier_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_rst_s1_q <= 1'b0;
      c_rst_n_q  <= 1'b0;
    end else begin
      c_rst_s1_q <= 1'b1;
      c_rst_n_q  <= c_rst_s1_q;
    end
  end

  // Field pin and request toggle enter the carrier domain through two stages
  always_ff @(posedge carrier_clk_i or negedge c_rst_n_q) begin
    if (!c_rst_n_q) begin
      req_s1_q   <= 1'b0;
      req_s2_q   <= 1'b0;
      fld_s1_q   <= 1'b1;
      fld_s2_q   <= 1'b1;
      fld_prev_q <= 1'b1;
    end else begin
      req_s1_q   <= req_q;
      req_s2_q   <= req_s1_q;
      fld_s1_q   <= field_i;
      fld_s2_q   <= fld_s1_q;
      fld_prev_q <= fld_s2_q;
    end
  end

  logic       gap_start;
  logic [5:0] per_cnt_q;
  logic [5:0] per_cnt_d;
  logic       counting_q;
  logic       counting_d;
  logic       sym_tog_d;
  logic       sym_bit_d;
  logic       sym_eof_d;

  // Falling field edge: high to low marks the start of a gap
  assign gap_start = fld_prev_q && !fld_s2_q;

  // One count per carrier period; both edges see the same sync delay
  always_comb begin
    per_cnt_d  = per_cnt_q;
    counting_d = counting_q;
    sym_tog_d  = sym_tog_q;
    sym_bit_d  = sym_bit_q;
    sym_eof_d  = sym_eof_q;
    if (gap_start) begin
      if (counting_q) begin
        sym_tog_d = ~sym_tog_q;
        sym_eof_d = 1'b0;
        sym_bit_d = (per_cnt_q >= rtac_pkg::ZERO_MAX_T);
      end
      per_cnt_d  = 6'h00;
      counting_d = 1'b1;
    end else if (counting_q) begin
      if (per_cnt_q == rtac_pkg::EOF_LAST_T) begin  // Interval exceeds 37 periods: close frame
        sym_tog_d  = ~sym_tog_q;
        sym_eof_d  = 1'b1;
        sym_bit_d  = 1'b0;
        counting_d = 1'b0;
      end else begin
        per_cnt_d = per_cnt_q + 6'h01;
      end
    end
  end

  // Register decoder state
  always_ff @(posedge carrier_clk_i or negedge c_rst_n_q) begin
    if (!c_rst_n_q) begin
      per_cnt_q  <= 6'h00;
      counting_q <= 1'b0;
      sym_tog_q  <= 1'b0;
      sym_bit_q  <= 1'b0;
      sym_eof_q  <= 1'b0;
    end else begin
      per_cnt_q  <= per_cnt_d;
      counting_q <= counting_d;
      sym_tog_q  <= sym_tog_d;
      sym_bit_q  <= sym_bit_d;
      sym_eof_q  <= sym_eof_d;
    end
  end

  typedef enum logic {RTAC_TX_IDLE, RTAC_TX_SEND} rtac_tx_state_t;
  rtac_tx_state_t tx_st_q;
  rtac_tx_state_t tx_st_d;
  logic           tx_ack_d;
  logic [6:0]     tick_q;
  logic [6:0]     tick_d;
  logic [6:0]     len_q;
  logic [6:0]     len_d;
  logic [1:0]     code_q;
  logic [1:0]     code_d;
  logic           bit_q;
  logic           bit_d;
  logic           bp_lvl_q;
  logic           bp_lvl_d;
  logic           mod_q;
  logic           mod_d;
  logic           pending;
  logic           bit_end;

  assign pending = (req_s2_q != tx_ack_q);
  assign bit_end = (tick_q == len_q - 7'h01);

  // Take a new bit only at a bit boundary so bits follow back to back
  always_comb begin
    tx_st_d  = tx_st_q;
    tx_ack_d = tx_ack_q;
    tick_d   = tick_q;
    len_d    = len_q;
    code_d   = code_q;
    bit_d    = bit_q;
    bp_lvl_d = bp_lvl_q;
    if (tx_st_q == RTAC_TX_IDLE || bit_end) begin
      if (pending) begin
        tx_st_d  = RTAC_TX_SEND;
        tx_ack_d = req_s2_q;
        tick_d   = 7'h00;
        len_d    = rtac_pkg::rtac_bit_len(hs_word_q[rtac_pkg::TXW_RATE +: 2]);
        code_d   = hs_word_q[rtac_pkg::TXW_CODE +: 2];
        bit_d    = hs_word_q[rtac_pkg::TXW_BIT];
        bp_lvl_d = ~mod_q;  // Biphase inverts the last driven level at every bit boundary
      end else begin
        tx_st_d = RTAC_TX_IDLE;
        tick_d  = 7'h00;
      end
    end else begin
      tick_d = tick_q + 7'h01;
    end
  end

  // Coded level for the current position inside the bit
  always_comb begin
    mod_d = 1'b0;
    if (tx_st_d == RTAC_TX_SEND) begin
      unique case (code_d)
        rtac_pkg::CODE_MC: mod_d = bit_d ? (tick_d < (len_d >> 1)) : (tick_d >= (len_d >> 1));
        rtac_pkg::CODE_BP: mod_d = (bit_d || tick_d < (len_d >> 1)) ? bp_lvl_d : ~bp_lvl_d;
        rtac_pkg::CODE_AC: mod_d = bit_d ? ((tick_d & ((len_d >> 1) - 7'h01)) < (len_d >> 2))
                                         : ((tick_d & ((len_d >> 1) - 7'h01)) >= (len_d >> 2));
        default:           mod_d = 1'b0;
      endcase
    end
  end

  // Register encoder state; modulator output straight from a flop
  always_ff @(posedge carrier_clk_i or negedge c_rst_n_q) begin
    if (!c_rst_n_q) begin
      tx_st_q  <= RTAC_TX_IDLE;
      tx_ack_q <= 1'b0;
      tick_q   <= 7'h00;
      len_q    <= rtac_pkg::BIT_LEN_4K;
      code_q   <= rtac_pkg::CODE_MC;
      bit_q    <= 1'b0;
      bp_lvl_q <= 1'b0;
      mod_q    <= 1'b0;
    end else begin
      tx_st_q  <= tx_st_d;
      tx_ack_q <= tx_ack_d;
      tick_q   <= tick_d;
      len_q    <= len_d;
      code_q   <= code_d;
      bit_q    <= bit_d;
      bp_lvl_q <= bp_lvl_d;
      mod_q    <= mod_d;
    end
  end

  // High level loads the field; idle leaves the modulator off
  assign load_mod_o = mod_q;

endmodule

`default_nettype wire

// ==== dv/rtac_air_coding_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module rtac_air_coding_monitor (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       carrier_clk_i,
  input wire logic       field_i,
  input wire logic       load_mod_o,
  input wire logic [1:0] op_state_i,
  input wire logic [1:0] req_variant_i,
  input wire logic       self_announce_code_bit_i,
  input wire logic [1:0] self_announce_rate_field_i,
  input wire logic       tx_valid_i,
  input wire logic       tx_bit_i,
  input wire logic       tx_ready_o,
  input wire logic       rx_valid_o,
  input wire logic       rx_bit_o,
  input wire logic       rx_eof_o,
  input wire logic       pigeon_race_o
);
  logic [6:0] run_q;
  logic [6:0] run_d;

  // Length of the current loaded stretch; saturates so it never wraps
  always_comb begin
    run_d = 7'h00;
    if (load_mod_o) run_d = (run_q == 7'h7f) ? run_q : run_q + 7'h01;
  end

  always_ff @(posedge carrier_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) run_q <= 7'h00;
    else run_q <= run_d;
  end

  // Loaded stretches are whole eighths of a slow bit, never longer than one slow bit
  a_high_run_len: assert property (@(posedge carrier_clk_i) disable iff (!rst_n_i)
    $fell(load_mod_o) |-> (run_q[2:0] == 3'h0 && run_q != 7'h00)) else $error("loaded stretch length odd");
  a_high_run_max: assert property (@(posedge carrier_clk_i) disable iff (!rst_n_i)
    load_mod_o |-> run_q < 7'h40) else $error("loaded stretch too long");

  // Decoder outputs
  a_rx_pulse_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_valid_o |=> !rx_valid_o [*8]) else $error("symbol pulses too close");
  a_eof_bit_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_eof_o |-> !rx_bit_o) else $error("frame end carries a bit");
  a_rx_hold_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rx_valid_o |-> $stable(rx_bit_o) && $stable(rx_eof_o)) else $error("symbol changed without pulse");

  // Pigeon flag follows the self-announce rate field one cycle later
  a_pigeon_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (op_state_i == rtac_pkg::OPST_SELF_ANNOUNCE && self_announce_rate_field_i == rtac_pkg::SA_RATE_2K_PIGEON)
    |=> pigeon_race_o) else $error("pigeon flag missing");
  a_pigeon_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(op_state_i == rtac_pkg::OPST_SELF_ANNOUNCE && self_announce_rate_field_i == rtac_pkg::SA_RATE_2K_PIGEON)
    |=> !pigeon_race_o) else $error("pigeon flag spurious");

  // The buffer only fills on an offered bit
  a_ready_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(tx_ready_o) |-> $past(tx_valid_i)) else $error("buffer filled without request");
endmodule

bind rtac_air_coding rtac_air_coding_monitor u_mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .carrier_clk_i(carrier_clk_i), .field_i(field_i),
  .load_mod_o(load_mod_o), .op_state_i(op_state_i), .req_variant_i(req_variant_i),
  .self_announce_code_bit_i(self_announce_code_bit_i), .self_announce_rate_field_i(self_announce_rate_field_i),
  .tx_valid_i(tx_valid_i), .tx_bit_i(tx_bit_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
  .rx_bit_o(rx_bit_o), .rx_eof_o(rx_eof_o), .pigeon_race_o(pigeon_race_o));

`default_nettype wire

// ==== dv/rtac_reader_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module rtac_reader_model (
  input  wire logic carrier_clk_i,
  input  wire logic load_mod_i,
  output logic      field_o
);
  logic rec_en;
  logic rec_q[$];

  // Field stays on between gaps: it powers the tag, so the carrier runs free
  initial begin
    field_o = 1'b1;
    rec_en  = 1'b0;
  end

  // A gap with the field fully off, then field on until the next gap start
  task automatic send_sym(input int gap, input int len);
    @(posedge carrier_clk_i);
    field_o <= 1'b0;
    repeat (gap) @(posedge carrier_clk_i);
    field_o <= 1'b1;
    repeat (len - gap - 1) @(posedge carrier_clk_i);
  endtask

  // Last gap start followed by a quiet stretch well past the frame-end limit
  task automatic close_frame;
    send_sym(6, 45);
  endtask

  task automatic start_rec;
    rec_q.delete();
    rec_en = 1'b1;
  endtask

  // Load seen by the reader, one sample per carrier period
  always @(posedge carrier_clk_i) begin
    if (rec_en) rec_q.push_back(load_mod_i);
  end
endmodule

`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic       clk_i, rst_n_i, carrier_clk_i, field, load_mod;
  logic [1:0] op_state, req_variant, sa_rate;
  logic       sa_code, tx_valid, tx_bit, tx_ready, rx_valid, rx_bit, rx_eof, pigeon;
  int         n_fail, checked;
  logic [1:0] rx_q[$];

  rtac_air_coding dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .carrier_clk_i(carrier_clk_i), .field_i(field),
    .load_mod_o(load_mod), .op_state_i(op_state), .req_variant_i(req_variant),
    .self_announce_code_bit_i(sa_code), .self_announce_rate_field_i(sa_rate), .tx_valid_i(tx_valid),
    .tx_bit_i(tx_bit), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_bit_o(rx_bit),
    .rx_eof_o(rx_eof), .pigeon_race_o(pigeon));
  rtac_reader_model reader (.carrier_clk_i(carrier_clk_i), .load_mod_i(load_mod), .field_o(field));

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;
  // Carrier offset so its edges never meet the system clock's
  initial begin
    carrier_clk_i = 1'b0;
    #3.7;
    forever #15 carrier_clk_i = ~carrier_clk_i;
  end

  // Decoded symbols in air order
  always @(posedge clk_i) begin
    if (rx_valid === 1'b1) rx_q.push_back({rx_eof, rx_bit});
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Sends n bits back to back and compares the load waveform, period by period
  task automatic run_tx(input logic [1:0] op, input logic [1:0] req, input logic cb, input logic [1:0] rf,
                        input logic [1:0] code, input int len, input logic [7:0] bits, input int n);
    logic exp_q[$];
    logic lvl;
    int   f, k, i, w;
    lvl = 1'b0;
    for (k = 0; k < n; k++) begin
      for (i = 0; i < len; i++) begin
        if (code == rtac_pkg::CODE_MC) lvl = bits[k] ? (i < len / 2) : (i >= len / 2);
        else if (code == rtac_pkg::CODE_AC) lvl = bits[k] ^ ((i / (len / 4)) % 2 == 1);
        else if (i == 0 || (i == len / 2 && !bits[k])) lvl = ~lvl;
        exp_q.push_back(lvl);
      end
    end
    @(posedge clk_i);
    op_state <= op;
    req_variant <= req;
    sa_code <= cb;
    sa_rate <= rf;
    @(posedge clk_i);
    reader.start_rec();
    for (k = 0; k < n; k++) begin
      tx_valid <= 1'b1;
      tx_bit <= bits[k];
      w = 0;
      do begin
        @(posedge clk_i);
        w++;
      end while (tx_ready !== 1'b1 && w < 5000);
    end
    tx_valid <= 1'b0;
    repeat (len * n + 16) @(posedge carrier_clk_i);
    f = 0;
    while (f < reader.rec_q.size() && reader.rec_q[f] !== 1'b1) f++;
    for (i = 0; i <= len * n; i++) begin
      check({7'h00, (f + i < reader.rec_q.size()) ? reader.rec_q[f + i] : 1'bx},
            {7'h00, (i < len * n) ? exp_q[i] : 1'b0});
    end
  endtask

  // Biphase: the first bit after an idle stretch opens high
  task automatic t_biphase;
    run_tx(rtac_pkg::OPST_SELF_ANNOUNCE, rtac_pkg::REQ_AC_2K, 1'b1, rtac_pkg::SA_RATE_8K,
           rtac_pkg::CODE_BP, 16, 8'h05, 4);
  endtask

  // Self-announce takes its rate from the stored field, whatever request is present
  task automatic t_sa_manchester;
    run_tx(rtac_pkg::OPST_SELF_ANNOUNCE, rtac_pkg::REQ_MC_8K, 1'b0, rtac_pkg::SA_RATE_2K,
           rtac_pkg::CODE_MC, 64, 8'h01, 2);
    run_tx(rtac_pkg::OPST_SELF_ANNOUNCE, rtac_pkg::REQ_AC_2K, 1'b0, rtac_pkg::SA_RATE_4K,
           rtac_pkg::CODE_MC, 32, 8'h05, 3);
    run_tx(rtac_pkg::OPST_SELF_ANNOUNCE, rtac_pkg::REQ_MC_4K, 1'b0, rtac_pkg::SA_RATE_2K_PIGEON,
           rtac_pkg::CODE_MC, 64, 8'h01, 2);
  endtask

  // Every request variant in both reader-first states; self-announce settings ignored
  task automatic t_reader_first;
    int r;
    for (r = 0; r < 4; r++) begin
      run_tx(rtac_pkg::OPST_INIT, 2'(r), 1'b1, 2'h1, rtac_pkg::CODE_AC, (r == 0) ? 64 : 32,
             8'h05, 3);
      run_tx(rtac_pkg::OPST_SELECTED, 2'(r), 1'b1, 2'h1, rtac_pkg::CODE_MC, (r == 3) ? 16 : 32,
             8'h05, 3);
    end
    // Reserved state code falls back to Manchester at 4 kbit/s whatever the request
    run_tx(2'h3, rtac_pkg::REQ_MC_8K, 1'b1, rtac_pkg::SA_RATE_8K, rtac_pkg::CODE_MC, 32, 8'h05, 3);
  endtask

  // Both gap lengths, both sides of the zero/one threshold, a long one of 36 periods, then frame end
  task automatic t_downlink;
    int gaps[5] = '{6, 9, 6, 9, 6};
    int lens[5] = '{20, 28, 24, 25, 36};
    logic exp_b[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    int k;
    rx_q.delete();
    for (k = 0; k < 5; k++) reader.send_sym(gaps[k], lens[k]);
    reader.close_frame();
    repeat (20) @(posedge clk_i);
    check(8'(rx_q.size()), 8'h06);
    for (k = 0; k < 5; k++) check({6'h00, rx_q[k]}, {7'h00, exp_b[k]});
    check({6'h00, rx_q[5]}, 8'h02);
  endtask

  // Pigeon flag for every state and rate setting
  task automatic t_pigeon;
    int o, r;
    for (o = 0; o < 4; o++) begin
      for (r = 0; r < 4; r++) begin
        op_state <= 2'(o);
        sa_rate <= 2'(r);
        repeat (2) @(posedge clk_i);
        check({7'h00, pigeon}, {7'h00, (2'(o) == rtac_pkg::OPST_SELF_ANNOUNCE &&
                                        2'(r) == rtac_pkg::SA_RATE_2K_PIGEON)});
      end
    end
  endtask

  initial begin
    n_fail = 0;
    checked = 0;
    rst_n_i = 1'b0;
    op_state = 2'h0;
    req_variant = 2'h0;
    sa_code = 1'b0;
    sa_rate = 2'h0;
    tx_valid = 1'b0;
    tx_bit = 1'b0;
    // Carrier side clears at once and releases two carrier edges after this
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge carrier_clk_i);
    t_biphase();
    t_sa_manchester();
    t_reader_first();
    t_downlink();
    t_pigeon();
    summarize();
  end

  // Hang guard, several times the expected run length
  initial begin
    #500000;
    n_fail++;
    summarize();
  end
endmodule

`default_nettype wire
